// ===== dv/qdpd_chk.sv
// assertions on the power-down control ports
// assumes one ref_clk domain, bound onto qdpd_ctrl
`timescale 1ns/1ps
`default_nettype none
module qdpd_chk (
   input wire logic ref_clk, // clock
   input wire logic rst_n, // reset
   input wire logic select_load_strobe_n, // frame
   input wire logic [3:0] chan_power_down, // flags
   input wire logic [3:0] amp_enable, // amps
   input wire logic [3:0] out_pulldown, // pulls
   input wire logic bias_enable, // bias
   input wire logic [3:0] chan_settling, // delay
   input wire logic [3:0] dac_update, // updates
   input wire logic [15:0] word_data // data
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // channel 0 waking, partly or fully down before
   sequence s_part;
      $fell(chan_power_down[0]) && !(&$past(chan_power_down));
   endsequence
   sequence s_full;
      $fell(chan_power_down[0]) && (&$past(chan_power_down));
   endsequence
   // some channel entering power-down
   sequence s_down;
      |(chan_power_down & ~$past(chan_power_down));
   endsequence
   AST_AMP: assert property (amp_enable == ~chan_power_down && out_pulldown == chan_power_down)
      else $error("enables");
   AST_BIAS: assert property (bias_enable == !(&chan_power_down)) else $error("bias");
   AST_IDLE: assert property (!select_load_strobe_n [*5] |-> $stable(chan_power_down)) else $error("idle");
   AST_DATA: assert property (s_down |-> $stable(word_data) && dac_update == 4'h0) else $error("data");
   AST_EXEC: assert property ((|dac_update) |-> $past(select_load_strobe_n, 2)) else $error("exec");
   AST_WAKE: assert property ((dac_update & chan_power_down) == 4'h0) else $error("wake");
   AST_PART: assert property (s_part |-> chan_settling[0]) else $error("part");
   AST_FULL: assert property (s_full |-> chan_settling[0] && bias_enable) else $error("full");
endmodule // qdpd_chk
`default_nettype wire

// ===== dv/qdpd_host.sv
// host model driving the three-wire command link
// assumes the bench calls send; link clock still between frames
`timescale 1ns/1ps
`default_nettype none
module qdpd_host (
   output logic sclk, // link clock
   output logic sdi, // data
   output logic strobe_n // select/load
);
   real hp = 62.5;
   // idle levels
   initial
   begin
      sclk = 1'b0;
      sdi = 1'b0;
      strobe_n = 1'b1;
   end
   // one framed word, msb first
   task automatic send(input logic [23:0] w);
      strobe_n = 1'b0;
      for (int i = 23; i >= 0; i--)
      begin
         sdi = w[i];
         #(hp) sclk = 1'b1;
         #(hp) sclk = 1'b0;
      end
      #(hp) strobe_n = 1'b1;
      sdi = ~sdi;
   endtask
endmodule // qdpd_host
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench for the power-down control block
// assumes host model and checker from dv/
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic ref_clk, rst_n, sclk, sdi, sln, sl, clr_n;
   logic [3:0] pd, upd, st, seen, xpd, ref_en, wr, wseen;
   logic [15:0] dat, xdat;
   logic [31:0] r;
   int err_total, checks, run, last;
   integer seed = 17;
   qdpd_host i_qdpd_host(.sclk(sclk), .sdi(sdi), .strobe_n(sln));
   qdpd_ctrl #(.WAKE_CYC(3), .WAKE_5V_CYC(5), .WAKE_3V_CYC(8)) i_qdpd_ctrl(.ref_clk(ref_clk), .rst_n(rst_n),
      .clear_n(clr_n), .sclk_pin(sclk), .sdi_pin(sdi), .select_load_strobe_n(sln), .supply_low(sl),
      .chan_power_down(pd), .amp_enable(), .ref_enable(ref_en), .out_pulldown(), .bias_enable(),
      .chan_settling(st), .dac_update(upd), .input_write(wr), .word_data(dat));
   // clock
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // update pulses and channel 0 settling length
   always @(negedge ref_clk)
   begin
      seen = seen | upd;
      wseen = wseen | wr;
      if (st[0] === 1'b1) run++;
      else if (run != 0)
      begin
         last = run;
         run = 0;
      end
   end
   function automatic logic [3:0] f_mask(input logic [3:0] a);
      return (a == 4'hf) ? 4'hf : (a < 4'h4) ? 4'h1 << a : 4'h0;
   endfunction
   task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e)
      begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   // one command word against the model state
   task automatic cmd(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d, input logic s);
      logic [3:0] m, u, w;
      int x;
      m = f_mask(a);
      w = (c == 4'h0 || c == 4'h2 || c == 4'h3) ? m : 4'h0;
      u = (c == 4'h2 && m != 4'h0) ? 4'hf : (c == 4'h1 || c == 4'h3) ? m : 4'h0;
      x = (u[0] && xpd[0]) ? ((&xpd) ? (s ? 8 : 5) : 3) : 0;
      if (c < 4'h4 && c != 4'h1 && m != 4'h0) xdat = d;
      xpd = (c == 4'h4) ? xpd | m : xpd & ~u;
      sl = s;
      seen = 4'h0;
      wseen = 4'h0;
      last = 0;
      i_qdpd_host.send({c, a, d});
      repeat (20) @(negedge ref_clk);
      cmp("power_down", {12'h0, xpd}, {12'h0, pd});
      cmp("update", {12'h0, u}, {12'h0, seen});
      cmp("data", xdat, dat);
      cmp("settle", x[15:0], last[15:0]);
      cmp("write", {12'h0, w}, {12'h0, wseen});
      cmp("ref_enable", {12'h0, ~xpd}, {12'h0, ref_en});
   endtask
   task automatic report_and_stop();
      if (err_total == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // reset, corner cases, then random words
   initial
   begin
      rst_n = 1'b0;
      sl = 1'b0;
      clr_n = 1'b1;
      seen = 4'h0;
      wseen = 4'h0;
      xpd = 4'h0;
      xdat = 16'h0;
      repeat (5) @(negedge ref_clk);
      rst_n = 1'b1;
      @(negedge ref_clk);
      cmd(4'h4, 4'h0, 16'hbeef, 1'b0);
      cmd(4'h1, 4'h0, 16'h0, 1'b0);
      cmd(4'h4, 4'hf, 16'h1234, 1'b0);
      cmd(4'h3, 4'h0, 16'h5a5a, 1'b0);
      cmd(4'h4, 4'hf, 16'h0, 1'b1);
      cmd(4'h1, 4'h0, 16'h0, 1'b1);
      cmd(4'h4, 4'hf, 16'hffff, 1'b1);
      cmd(4'h2, 4'h3, 16'h7777, 1'b1);
      cmd(4'h5, 4'h1, 16'h1111, 1'b0);
      cmd(4'h4, 4'h7, 16'h2222, 1'b0);
      cmd(4'hf, 4'hf, 16'h3333, 1'b0);
      cmd(4'h0, 4'h2, 16'h4444, 1'b0);
      cmd(4'h2, 4'h7, 16'h9999, 1'b0);
      cmd(4'h4, 4'h1, 16'h6666, 1'b0);
      // clear pulse: codes zeroed, power flags kept
      clr_n = 1'b0;
      repeat (4) @(negedge ref_clk);
      clr_n = 1'b1;
      xdat = 16'h0;
      repeat (4) @(negedge ref_clk);
      cmp("clear_data", xdat, dat);
      cmp("clear_power_down", {12'h0, xpd}, {12'h0, pd});
      // reset in mid-run
      rst_n = 1'b0;
      repeat (2) @(negedge ref_clk);
      rst_n = 1'b1;
      xpd = 4'h0;
      @(negedge ref_clk);
      cmp("reset_power_down", {12'h0, xpd}, {12'h0, pd});
      cmp("reset_data", xdat, dat);
      repeat (30)
      begin
         r = $random(seed);
         cmd((r[2:0] > 3'h4) ? 4'h4 : {1'b0, r[2:0]}, r[4] ? 4'hf : {2'b0, r[6:5]}, r[31:16], r[7]);
      end
      report_and_stop();
   end
   // hang guard
   initial
   begin
      #800000;
      err_total++;
      report_and_stop();
   end
endmodule // tb
bind qdpd_ctrl qdpd_chk i_qdpd_chk(.ref_clk(ref_clk), .rst_n(rst_n), .select_load_strobe_n(select_load_strobe_n),
   .chan_power_down(chan_power_down), .amp_enable(amp_enable), .out_pulldown(out_pulldown),
   .bias_enable(bias_enable), .chan_settling(chan_settling), .dac_update(dac_update), .word_data(word_data));
`default_nettype wire

// ===== verilog/qdpd_ctrl.sv
// holds the serial command decoder and per-channel power state
// assumes serial pins are asynchronous and synchronised inside
`timescale 1ns/1ps
`default_nettype none
`include "qdpd_defines.svh"
module qdpd_ctrl
   import qdpd_pkg::*;
#(
   parameter int NCH = 4,
   parameter int WAKE_CYC = `QDPD_WAKE_CYC,
   parameter int WAKE_5V_CYC = `QDPD_WAKE_FULL_5V_CYC,
   parameter int WAKE_3V_CYC = `QDPD_WAKE_FULL_3V_CYC,
   parameter int CW = 16
) (
   input wire logic ref_clk, // 100 MHz core clock
   input wire logic rst_n, // async reset, active low
   input wire logic clear_n, // async clear pin, active low
   input wire logic sclk_pin, // serial clock
   input wire logic sdi_pin, // serial data
   input wire logic select_load_strobe_n, // select/load, active low
   input wire logic supply_low, // 1 for 3V supply timing
   output logic [NCH-1:0] chan_power_down, // per-channel low-power flag
   output logic [NCH-1:0] amp_enable, // output amplifier enable
   output logic [NCH-1:0] ref_enable, // reference input enable
   output logic [NCH-1:0] out_pulldown, // hi-z output with pull to ground
   output logic bias_enable, // shared bias generator enable
   output logic [NCH-1:0] chan_settling, // wake delay running
   output logic [NCH-1:0] dac_update, // one-cycle update pulse
   output logic [NCH-1:0] input_write, // one-cycle input write pulse
   output logic [CW-1:0] word_data // data field of last word that wrote a channel
);
   // elaboration check: decode assumes four channels, counter sized by longest wake
   if (NCH != 4 || CW != 16 || WAKE_CYC < 1 || WAKE_5V_CYC < 1 || WAKE_3V_CYC < WAKE_5V_CYC ||
       WAKE_CYC > WAKE_3V_CYC)
   begin : g_param_check
      $error("qdpd_ctrl: unsupported parameters");
   end

   localparam int CNTW = $clog2(WAKE_3V_CYC + 1);

   typedef struct packed {
      qdpd_state_t st;
      logic sclk_d;
      logic clr_m;
      logic clr_s;
      logic [`QDPD_WORD_BITS-1:0] sh;
      logic [NCH-1:0] pd;
      logic [NCH-1:0] amp;
      logic [NCH-1:0] refe;
      logic [NCH-1:0] pull;
      logic bias;
      logic [NCH-1:0] upd;
      logic [NCH-1:0] wr;
      logic [CW-1:0] data;
      logic [NCH-1:0] settle;
      logic [NCH-1:0][CNTW-1:0] cnt;
   } qdpd_ctrl_st_t;

   qdpd_ctrl_st_t s_q, s_d;
   qdpd_sync_if sy ();

   // pin synchroniser
   qdpd_sync u_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .sclk_pin(sclk_pin),
      .sdi_pin(sdi_pin),
      .strobe_n_pin(select_load_strobe_n),
      .sy(sy)
   );

   logic [3:0] cmd;
   logic [3:0] adr;
   logic [NCH-1:0] sel;
   logic is_upd;
   logic all_down;
   logic [CNTW-1:0] wake_len;

   // word decode
   always_comb
   begin
      cmd = s_q.sh[`QDPD_CMD_MSB:`QDPD_CMD_LSB];
      adr = s_q.sh[`QDPD_ADR_MSB:`QDPD_ADR_LSB];
      sel = '0;
      if (adr == `QDPD_ADDR_ALL)
      begin
         sel = '1;
      end
      else if (adr < 4'(NCH))
      begin
         sel[adr[1:0]] = 1'b1;
      end
      is_upd = (cmd == `QDPD_CMD_UPDATE) || (cmd == `QDPD_CMD_WRITE_UPD_ALL) ||
               (cmd == `QDPD_CMD_WRITE_UPD);
      all_down = &s_q.pd;
      if (all_down)
      begin
         wake_len = supply_low ? CNTW'(WAKE_3V_CYC) : CNTW'(WAKE_5V_CYC);
      end
      else
      begin
         wake_len = CNTW'(WAKE_CYC);
      end
   end

   logic [NCH-1:0] up_sel;
   logic [NCH-1:0] wr_sel;
   logic [NCH-1:0] wake_go;

   // next state
   always_comb
   begin
      s_d = s_q;
      up_sel = '0;
      wr_sel = '0;
      wake_go = '0;
      s_d.clr_m = clear_n;
      s_d.clr_s = s_q.clr_m;
      s_d.sclk_d = sy.sclk_s;
      s_d.upd = '0;
      s_d.wr = '0;
      unique case (s_q.st)
         QDPD_IDLE:
         begin
            if (!sy.strobe_s)
            begin
               s_d.st = QDPD_SHIFT;
            end
         end
         QDPD_SHIFT:
         begin
            if (sy.sclk_s && !s_q.sclk_d)
            begin
               s_d.sh = {s_q.sh[`QDPD_WORD_BITS-2:0], sy.sdi_s};
            end
            if (sy.strobe_s)
            begin
               s_d.st = QDPD_EXEC;
            end
         end
         QDPD_EXEC:
         begin
            s_d.st = QDPD_IDLE;
            if (cmd == `QDPD_CMD_POWER_DOWN)
            begin
               s_d.pd = s_q.pd | sel;
               // data field deliberately not latched
            end
            else if (is_upd)
            begin
               // reserved address selects nothing, so nothing moves
               if (cmd == `QDPD_CMD_WRITE_UPD_ALL)
               begin
                  up_sel = {NCH{|sel}};
               end
               else
               begin
                  up_sel = sel;
               end
               if (cmd != `QDPD_CMD_UPDATE && (|sel))
               begin
                  wr_sel = sel;
                  s_d.data = s_q.sh[CW-1:0];
               end
               s_d.upd = up_sel;
               s_d.wr = wr_sel;
               for (int i = 0; i < NCH; i++)
               begin
                  if (up_sel[i] && s_q.pd[i])
                  begin
                     wake_go[i] = 1'b1;
                     s_d.settle[i] = 1'b1;
                     s_d.cnt[i] = wake_len;
                  end
               end
               s_d.pd = s_q.pd & ~up_sel;
            end
            else if (cmd == `QDPD_CMD_WRITE && (|sel))
            begin
               s_d.wr = sel;
               s_d.data = s_q.sh[CW-1:0];
            end
         end
      endcase
      // wake delay countdown
      for (int i = 0; i < NCH; i++)
      begin
         if (s_q.settle[i] && !wake_go[i]) // fresh load wins over countdown
         begin
            if (s_q.cnt[i] <= CNTW'(1))
            begin
               s_d.settle[i] = 1'b0;
               s_d.cnt[i] = '0;
            end
            else
            begin
               s_d.cnt[i] = s_q.cnt[i] - CNTW'(1);
            end
         end
      end
      // analog enables follow flags only; codes untouched
      s_d.amp = ~s_d.pd;
      s_d.refe = ~s_d.pd;
      s_d.pull = s_d.pd;
      s_d.bias = ~(&s_d.pd);
      // clear zeroes codes, leaves power state
      if (!s_q.clr_s)
      begin
         s_d.data = '0;
      end
   end

   // state register
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q <= '0;
         s_q.st <= QDPD_IDLE;
         s_q.amp <= '1;
         s_q.refe <= '1;
         s_q.bias <= 1'b1;
         s_q.clr_m <= 1'b1;
         s_q.clr_s <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign chan_power_down = s_q.pd;
   assign amp_enable = s_q.amp;
   assign ref_enable = s_q.refe;
   assign out_pulldown = s_q.pull;
   assign bias_enable = s_q.bias;
   assign chan_settling = s_q.settle;
   assign dac_update = s_q.upd;
   assign input_write = s_q.wr;
   assign word_data = s_q.data;
endmodule // qdpd_ctrl
`default_nettype wire

// ===== verilog/qdpd_defines.svh
// constants for the quad converter power-down control block
// assumes a 100 MHz ref_clk; included by bare name
`ifndef QDPD_DEFINES_SVH
`define QDPD_DEFINES_SVH
`define QDPD_CMD_WRITE 4'h0
`define QDPD_CMD_UPDATE 4'h1
`define QDPD_CMD_WRITE_UPD_ALL 4'h2
`define QDPD_CMD_WRITE_UPD 4'h3
`define QDPD_CMD_POWER_DOWN 4'h4
`define QDPD_CMD_NOP 4'hf
`define QDPD_ADDR_ALL 4'hf
`define QDPD_WORD_BITS 24
`define QDPD_CLK_MHZ 100
`define QDPD_WAKE_US 5
`define QDPD_WAKE_FULL_5V_US 12
`define QDPD_WAKE_FULL_3V_US 30
`define QDPD_WAKE_CYC (`QDPD_WAKE_US * `QDPD_CLK_MHZ)
`define QDPD_WAKE_FULL_5V_CYC (`QDPD_WAKE_FULL_5V_US * `QDPD_CLK_MHZ)
`define QDPD_WAKE_FULL_3V_CYC (`QDPD_WAKE_FULL_3V_US * `QDPD_CLK_MHZ)
`define QDPD_CMD_MSB 23
`define QDPD_CMD_LSB 20
`define QDPD_ADR_MSB 19
`define QDPD_ADR_LSB 16
`endif

// ===== verilog/qdpd_pkg.sv
// types for the quad converter power-down control block
// assumes nothing beyond the defines header
package qdpd_pkg;
   typedef enum logic [2:0] {
      QDPD_IDLE = 3'b001,
      QDPD_SHIFT = 3'b010,
      QDPD_EXEC = 3'b100
   } qdpd_state_t;
endpackage

// ===== verilog/qdpd_sync.sv
// two-flop synchroniser for the three serial pins
// assumes pins are asynchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module qdpd_sync (
   input wire logic ref_clk, // core clock
   input wire logic rst_n, // async reset, active low
   input wire logic sclk_pin, // serial clock pin
   input wire logic sdi_pin, // serial data pin
   input wire logic strobe_n_pin, // select/load pin
   qdpd_sync_if.src sy // synchronised levels
);
   typedef struct packed {
      logic [2:0] m;
      logic [2:0] s;
   } qdpd_sync_st_t;
   qdpd_sync_st_t st_q, st_d;
   // first stage only feeds second stage
   always_comb
   begin
      st_d = st_q;
      st_d.m = {sclk_pin, sdi_pin, strobe_n_pin};
      st_d.s = st_q.m;
   end
   // strobe idles high
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q <= 6'h09;
      end
      else
      begin
         st_q <= st_d;
      end
   end
   assign sy.sclk_s = st_q.s[2];
   assign sy.sdi_s = st_q.s[1];
   assign sy.strobe_s = st_q.s[0];
endmodule // qdpd_sync
`default_nettype wire

// ===== verilog/qdpd_sync_if.sv
// bundle between the pin synchroniser and the control core
// assumes both ends run on ref_clk
`timescale 1ns/1ps
`default_nettype none
interface qdpd_sync_if;
   logic sclk_s;
   logic sdi_s;
   logic strobe_s;
   modport src (output sclk_s, output sdi_s, output strobe_s);
   modport dst (input sclk_s, input sdi_s, input strobe_s);
endinterface
`default_nettype wire
